// file: design/nvm_ctrl.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "nvm_map.svh"
// How it works
// - one erase command clears exactly one 64-byte, 32-word flash block
// - no single-word erase path exists; block is the smallest unit
// - start happens only after keys 55h then 0AAh and then start bit
// - flash erase stalls the CPU for the whole erase
// - the programming timer alone ends every long write
// - EEPROM read: load address, clear program select, set read bit; one cycle
// - data register keeps the read byte until next read or software write
// - start bit ignored while write permit is clear
// - permit must be set by an earlier write; same write cannot start
// - hardware never clears write permit
// - once started, control, address and data are frozen until the end
// - at the end start bit clears and the complete flag sets
// - complete flag stays set until software clears it; poll or interrupt
// - software can only set the start bit; hardware clears it
// - abort flag sets with start, clears on normal completion
// - key port reads back as zero
// - config select overrides program select; else program select picks target
module nvm_ctrl
    import nvm_pkg::*;
#(
    parameter int EE_ADDR_W = 10,
    parameter int ERASE_US = `NVM_ERASE_US,
    parameter int EE_WRITE_US = `NVM_EE_WRITE_US
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [`NVM_ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic cpu_stall_out,
    output logic erase_active_out,
    output logic [15:0] erase_block_out,
    output logic cfg_active_out,
    output logic [21:0] cfg_ptr_out,
    output logic write_complete_out
);
    localparam logic [7:0] TICK_LAST = 8'(`NVM_TICK_CYCLES - 1);
    localparam logic [23:0] ERASE_TICKS = 24'(ERASE_US);
    localparam logic [23:0] EE_TICKS = 24'(EE_WRITE_US);

    ctrl_state_type s_reg;
    ctrl_state_type s_next;
    nvm_store_if #(.ADDR_W(EE_ADDR_W)) sif ();

    logic tick;
    logic wr_ctrl;
    logic wr_key;
    logic idle;
    logic finish;
    logic go;
    logic pgm_w;
    logic cfg_w;
    logic era_w;
    op_type op_w;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    // ****************************************
    // decode and timer strobes
    // ****************************************
    assign tick = (s_reg.tick_cnt == TICK_LAST);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `NVM_OFS_CTRL);
    assign wr_key = reg_wr_in && (reg_addr_in == `NVM_OFS_KEY);
    assign idle = (s_reg.op == OP_IDLE);
    assign finish = !idle && tick && (s_reg.timer == 24'h000001);
    assign pgm_w = reg_wdata_in[`NVM_B_PGM];
    assign cfg_w = reg_wdata_in[`NVM_B_CFG];
    assign era_w = reg_wdata_in[`NVM_B_ERASE];

    // target chosen by the write that sets start
    always_comb begin
        if (cfg_w) begin
            op_w = OP_CFG;
        end else if (!pgm_w) begin
            op_w = OP_EE_WRITE;
        end else if (era_w) begin
            op_w = OP_ERASE;
        end else begin
            op_w = OP_IDLE; // row writes are not handled here
        end
    end

    // keys armed, start bit, permit from before
    assign go = wr_ctrl && idle && reg_wdata_in[`NVM_B_START] && s_reg.permit
        && (s_reg.key == KEY_ARMED) && (op_w != OP_IDLE);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.ee_wr = 1'b0;
        s_next.tick_cnt = tick ? 8'h00 : s_reg.tick_cnt + 8'h01;

        if (wr_key) begin
            if (reg_wdata_in == `NVM_KEY_FIRST) begin
                s_next.key = KEY_GOT_FIRST;
            end else if (reg_wdata_in == `NVM_KEY_SECOND && s_reg.key == KEY_GOT_FIRST) begin
                s_next.key = KEY_ARMED;
            end else begin
                s_next.key = KEY_IDLE;
            end
        end else if (reg_wr_in) begin
            s_next.key = KEY_IDLE;
        end

        if (wr_ctrl && idle) begin
            s_next.pgm_sel = pgm_w;
            s_next.cfg_sel = cfg_w;
            s_next.erase_sel = era_w;
            s_next.abort_flag = reg_wdata_in[`NVM_B_ABORT];
            s_next.permit = reg_wdata_in[`NVM_B_PERMIT];
            s_next.read_pend = reg_wdata_in[`NVM_B_READ] && !pgm_w && !cfg_w;
        end
        if (reg_wr_in && idle) begin
            case (reg_addr_in)
                `NVM_OFS_DATA: s_next.data = reg_wdata_in;
                `NVM_OFS_ADDR_LO: s_next.addr_lo = reg_wdata_in;
                `NVM_OFS_ADDR_HI: s_next.addr_hi = reg_wdata_in;
                `NVM_OFS_PTR_LO: s_next.ptr[7:0] = reg_wdata_in;
                `NVM_OFS_PTR_HI: s_next.ptr[15:8] = reg_wdata_in;
                `NVM_OFS_PTR_UP: s_next.ptr[21:16] = reg_wdata_in[5:0];
                default: ;
            endcase
        end

        // data only changes on a read or a software write
        if (s_reg.read_pend) begin
            s_next.data = sif.rdata;
            s_next.read_pend = 1'b0;
        end

        // start is set here and cleared only at finish
        if (go) begin
            s_next.start = 1'b1;
            // abort flag armed for the cycle
            s_next.abort_flag = 1'b1;
            s_next.op = op_w;
            s_next.timer = (op_w == OP_ERASE) ? ERASE_TICKS : EE_TICKS;
        end else if (!idle && tick) begin
            s_next.timer = s_reg.timer - 24'h000001;
        end

        // end of cycle: start off, flag on
        if (finish) begin
            s_next.start = 1'b0;
            s_next.abort_flag = 1'b0;
            s_next.done_flag = 1'b1;
            s_next.op = OP_IDLE;
            s_next.ee_wr = (s_reg.op == OP_EE_WRITE);
        end else if (reg_wr_in && reg_addr_in == `NVM_OFS_STATUS
                && reg_wdata_in[`NVM_B_DONE]) begin
            // software clear, loses to a same-cycle set
            s_next.done_flag = 1'b0;
        end

        // stall for erase, one block out
        s_next.stall = (s_next.op == OP_ERASE);
        s_next.erase_act = (s_next.op == OP_ERASE);
        s_next.cfg_act = (s_next.op == OP_CFG);

        // read data, registered one cycle after the strobe
        s_next.rdata = `NVM_BYTE_RST;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `NVM_OFS_CTRL: s_next.rdata = {s_reg.pgm_sel, s_reg.cfg_sel, 1'b0,
                    s_reg.erase_sel, s_reg.abort_flag, s_reg.permit, s_reg.start,
                    s_reg.read_pend};
                `NVM_OFS_KEY: s_next.rdata = `NVM_BYTE_RST;
                `NVM_OFS_DATA: s_next.rdata = s_reg.data;
                `NVM_OFS_ADDR_LO: s_next.rdata = s_reg.addr_lo;
                `NVM_OFS_ADDR_HI: s_next.rdata = s_reg.addr_hi;
                `NVM_OFS_PTR_LO: s_next.rdata = s_reg.ptr[7:0];
                `NVM_OFS_PTR_HI: s_next.rdata = s_reg.ptr[15:8];
                `NVM_OFS_PTR_UP: s_next.rdata = {2'b00, s_reg.ptr[21:16]};
                `NVM_OFS_STATUS: s_next.rdata = {7'h00, s_reg.done_flag};
                default: s_next.rdata = `NVM_BYTE_RST;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_reg <= '{pgm_sel: 1'b0, cfg_sel: 1'b0, erase_sel: 1'b0,
                abort_flag: 1'b0, permit: 1'b0, start: 1'b0, read_pend: 1'b0,
                key: KEY_IDLE, op: OP_IDLE, data: `NVM_BYTE_RST,
                addr_lo: `NVM_BYTE_RST, addr_hi: `NVM_BYTE_RST, ptr: `NVM_PTR_RST,
                done_flag: 1'b0, tick_cnt: 8'h00, timer: 24'h000000,
                rdata: `NVM_BYTE_RST, ee_wr: 1'b0, stall: 1'b0,
                erase_act: 1'b0, cfg_act: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // EEPROM array and outputs
    // ****************************************
    assign sif.wr_en = s_reg.ee_wr;
    assign sif.addr = EE_ADDR_W'({s_reg.addr_hi, s_reg.addr_lo});
    assign sif.wdata = s_reg.data;

    nvm_ee_store #(.ADDR_W(EE_ADDR_W)) u_store (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .port(sif.store)
    );

    assign reg_rdata_out = s_reg.rdata;
    assign cpu_stall_out = s_reg.stall;
    assign erase_active_out = s_reg.erase_act;
    // low six pointer bits dropped, block granularity only
    assign erase_block_out = s_reg.ptr[21:6];
    assign cfg_active_out = s_reg.cfg_act;
    assign cfg_ptr_out = s_reg.ptr;
    assign write_complete_out = s_reg.done_flag;

    // ****************************************
    // checks
    // ****************************************
    sequence key_first_s;
        wr_key && reg_wdata_in == `NVM_KEY_FIRST;
    endsequence
    sequence key_second_s;
        wr_key && reg_wdata_in == `NVM_KEY_SECOND;
    endsequence
    sequence start_wr_s;
        wr_ctrl && reg_wdata_in[`NVM_B_START] && !cfg_w && !pgm_w && s_reg.permit && idle;
    endsequence

    unlock_start_a: assert property (key_first_s ##1 key_second_s ##1 start_wr_s
        |=> s_reg.start && s_reg.op == OP_EE_WRITE) else $error("unlock did not start");
    start_armed_a: assert property ($rose(s_reg.start)
        |-> $past(s_reg.key) == KEY_ARMED) else $error("start without keys");
    permit_gate_a: assert property (wr_ctrl && !s_reg.permit
        |=> !$rose(s_reg.start)) else $error("start without permit");
    permit_hold_a: assert property (s_reg.permit && !wr_ctrl
        |=> s_reg.permit) else $error("permit dropped");
    erase_stall_a: assert property ($rose(s_reg.op == OP_ERASE)
        |=> cpu_stall_out && erase_active_out) else $error("no stall on erase");
    timer_end_a: assert property ($fell(s_reg.start)
        |-> $past(tick) && $past(s_reg.timer) == 24'h000001) else $error("early end");
    read_lat_a: assert property (wr_ctrl && idle && reg_wdata_in[`NVM_B_READ] && !pgm_w
        && !cfg_w |=> ##1 s_reg.data == $past(sif.rdata)) else $error("read late");
    data_hold_a: assert property (!s_reg.read_pend && !(reg_wr_in
        && reg_addr_in == `NVM_OFS_DATA) |=> $stable(s_reg.data)) else $error("data moved");
    busy_freeze_a: assert property (!idle && reg_wr_in && reg_addr_in == `NVM_OFS_ADDR_LO
        |=> $stable(s_reg.addr_lo)) else $error("address changed while busy");
    done_flag_a: assert property ($fell(s_reg.start)
        |-> s_reg.done_flag && !s_reg.abort_flag) else $error("no completion flag");
    start_stick_a: assert property (s_reg.start && !finish
        |=> s_reg.start) else $error("start cleared early");
    abort_set_a: assert property ($rose(s_reg.start)
        |-> s_reg.abort_flag) else $error("abort flag not set");
    key_zero_a: assert property (reg_rd_in && reg_addr_in == `NVM_OFS_KEY
        |=> reg_rdata_out == 8'h00) else $error("key port read nonzero");
    cfg_wins_a: assert property ($rose(s_reg.start) && s_reg.cfg_sel
        |-> s_reg.op == OP_CFG) else $error("config select ignored");

endmodule : nvm_ctrl

// file: design/nvm_ee_store.sv
`timescale 1ns/1ns
`include "nvm_map.svh"
module nvm_ee_store #(
    parameter int ADDR_W = 10
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    nvm_store_if.store port
);
    localparam int DEPTH = 1 << ADDR_W;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } store_state_type;

    store_state_type s_reg;
    store_state_type s_next;

    // ****************************************
    // byte array, written only at cycle end
    // ****************************************
    always_comb begin
        s_next = s_reg;
        if (port.wr_en) begin
            s_next.mem[port.addr] = port.wdata;
        end
    end

    // cells come out of reset erased
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_reg <= {DEPTH{`NVM_EE_ERASED}};
        end else begin
            s_reg <= s_next;
        end
    end

    // read is a plain index into the flops
    assign port.rdata = s_reg.mem[port.addr];

endmodule : nvm_ee_store

// file: dv/nvm_cpu_model.sv
`timescale 1ns/1ns
`include "nvm_map.svh"
// ****************************************
// firmware side of the register port
// ****************************************
module nvm_cpu_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] rdata_in,
    output logic [`NVM_ADDR_W-1:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    // one write cycle; strobe dropped by the next task, never twice per step
    task wr(input logic [`NVM_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        rd_out <= 1'b0;
    endtask : wr

    // bus idle for one cycle, then let the edge settle
    task idle();
        @(posedge clk_sys_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        #1;
    endtask : idle

    // read data stands only in the cycle after the strobe
    task rd(input logic [`NVM_ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge clk_sys_in);
        addr_out <= a;
        wr_out <= 1'b0;
        rd_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_out <= 1'b0;
        #1 v = rdata_in;
    endtask : rd

    // key pair then start, nothing in between
    task unlock(input logic [7:0] ctrl);
        wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
        wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
        wr(`NVM_OFS_CTRL, ctrl);
    endtask : unlock

    // data first, permit on an earlier write
    task ee_write(input logic [7:0] d);
        wr(`NVM_OFS_DATA, d);
        wr(`NVM_OFS_CTRL, 8'h04);
        unlock(8'h06);
    endtask : ee_write

    // read start also drops the permit again
    task ee_read();
        wr(`NVM_OFS_CTRL, 8'h01);
        idle();
    endtask : ee_read

    // program select, permit, erase select, no config
    task erase_setup();
        wr(`NVM_OFS_CTRL, 8'h94);
    endtask : erase_setup
endmodule : nvm_cpu_model

// file: dv/tb_top.sv
`timescale 1ns/1ns
`include "nvm_map.svh"
module tb_top;
    logic clk_sys_in;
    logic resetn_in;
    logic [`NVM_ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] rdata;
    logic stall;
    logic erase_act;
    logic [15:0] erase_blk;
    logic cfg_act;
    logic [21:0] cfg_ptr;
    logic done;
    int failures;
    int n_checks;
    int n;
    logic [21:0] ptr;

    // short timer counts keep the run brief
    nvm_ctrl #(.ERASE_US(3), .EE_WRITE_US(4)) dut_u (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .cpu_stall_out(stall), .erase_active_out(erase_act),
        .erase_block_out(erase_blk), .cfg_active_out(cfg_act), .cfg_ptr_out(cfg_ptr),
        .write_complete_out(done));

    nvm_cpu_model cpu_u (
        .clk_sys_in(clk_sys_in), .rdata_in(rdata), .addr_out(reg_addr),
        .wdata_out(reg_wdata), .wr_out(reg_wr), .rd_out(reg_rd));

    // ****************************************
    // clock, checks and verdict
    // ****************************************
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task chk(input string s, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", s, exp, got);
        end
    endtask : chk

    task rdc(input logic [3:0] a, input logic [7:0] e, input string s);
        logic [7:0] v;
        cpu_u.rd(a, v);
        chk(s, v, e);
    endtask : rdc

    // bounded wait for the done flag or for the stall to drop
    task wait_for(input bit want_done, output int cnt);
        cnt = 0;
        while ((want_done ? done !== 1'b1 : stall === 1'b1) && cnt < 1000) begin
            @(posedge clk_sys_in);
            #1;
            cnt++;
        end
    endtask : wait_for

    task results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // watchdog well beyond the expected run of about 1200 cycles
    initial begin
        #200000;
        failures++;
        $display("Error watchdog expected finish seen hang");
        results();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        failures = 0;
        n_checks = 0;
        resetn_in = 1'b0;
        // strobes go low at the first edge, still inside reset
        cpu_u.idle();
        repeat (7) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        rdc(`NVM_OFS_CTRL, 8'h00, "ctrl reset");
        rdc(4'hF, 8'h00, "unmapped read");
        cpu_u.wr(`NVM_OFS_KEY, 8'h5A);
        rdc(`NVM_OFS_KEY, 8'h00, "key readback");
        // cells come up erased
        cpu_u.wr(`NVM_OFS_ADDR_LO, 8'h05);
        cpu_u.wr(`NVM_OFS_ADDR_HI, 8'h01);
        cpu_u.ee_read();
        rdc(`NVM_OFS_DATA, `NVM_EE_ERASED, "erased cell");
        // byte write, with attempted changes while busy
        cpu_u.ee_write(8'h3C);
        rdc(`NVM_OFS_CTRL, 8'h0E, "ctrl busy");
        cpu_u.wr(`NVM_OFS_DATA, 8'h77);
        cpu_u.wr(`NVM_OFS_CTRL, 8'h04);
        cpu_u.wr(`NVM_OFS_ADDR_LO, 8'h09);
        rdc(`NVM_OFS_CTRL, 8'h0E, "start kept");
        rdc(`NVM_OFS_DATA, 8'h3C, "data frozen");
        rdc(`NVM_OFS_ADDR_LO, 8'h05, "addr frozen");
        wait_for(1'b1, n);
        chk("ee done", done, 1'b1);
        rdc(`NVM_OFS_CTRL, 8'h04, "ctrl after write");
        repeat (5) cpu_u.idle();
        rdc(`NVM_OFS_STATUS, 8'h01, "flag sticky");
        cpu_u.wr(`NVM_OFS_STATUS, 8'h01);
        rdc(`NVM_OFS_STATUS, 8'h00, "flag cleared");
        cpu_u.wr(`NVM_OFS_DATA, 8'h00);
        cpu_u.ee_read();
        rdc(`NVM_OFS_DATA, 8'h3C, "cell readback");
        rdc(`NVM_OFS_DATA, 8'h3C, "data held");
        // refused starts: permit in same write, no permit, no keys, broken keys
        cpu_u.wr(`NVM_OFS_CTRL, 8'h00);
        cpu_u.unlock(8'h06);
        rdc(`NVM_OFS_CTRL, 8'h04, "same write start");
        cpu_u.wr(`NVM_OFS_CTRL, 8'h00);
        cpu_u.unlock(8'h02);
        rdc(`NVM_OFS_CTRL, 8'h00, "no permit start");
        cpu_u.wr(`NVM_OFS_CTRL, 8'h04);
        cpu_u.wr(`NVM_OFS_CTRL, 8'h06);
        rdc(`NVM_OFS_CTRL, 8'h04, "no key start");
        cpu_u.wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
        cpu_u.wr(`NVM_OFS_DATA, 8'h11);
        cpu_u.wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
        cpu_u.wr(`NVM_OFS_CTRL, 8'h06);
        rdc(`NVM_OFS_CTRL, 8'h04, "broken keys");
        chk("no done", done, 1'b0);
        // program select without erase select is a row write: refused
        cpu_u.wr(`NVM_OFS_CTRL, 8'h84);
        cpu_u.unlock(8'h86);
        rdc(`NVM_OFS_CTRL, 8'h84, "row write refused");
        // block erase with low pointer bits all ones
        cpu_u.wr(`NVM_OFS_PTR_LO, 8'h7F);
        cpu_u.wr(`NVM_OFS_PTR_HI, 8'hA5);
        cpu_u.wr(`NVM_OFS_PTR_UP, 8'h3F);
        ptr = {6'h3F, 8'hA5, 8'h7F};
        rdc(`NVM_OFS_PTR_UP, 8'h3F, "ptr upper");
        cpu_u.erase_setup();
        cpu_u.unlock(8'h96);
        cpu_u.idle();
        chk("stall", stall, 1'b1);
        chk("erase active", erase_act, 1'b1);
        chk("erase block", erase_blk, ptr[21:6]);
        chk("cfg idle", cfg_act, 1'b0);
        wait_for(1'b0, n);
        chk("erase length", (n >= 195 && n <= 310), 1'b1);
        chk("erase done", done, 1'b1);
        chk("erase ended", erase_act, 1'b0);
        // config select wins over program select clear
        cpu_u.wr(`NVM_OFS_STATUS, 8'h01);
        cpu_u.wr(`NVM_OFS_CTRL, 8'h44);
        cpu_u.unlock(8'h46);
        cpu_u.idle();
        chk("cfg active", cfg_act, 1'b1);
        chk("cfg pointer", cfg_ptr, ptr);
        chk("cfg no stall", stall, 1'b0);
        wait_for(1'b1, n);
        chk("cfg done", done, 1'b1);
        chk("cfg ended", cfg_act, 1'b0);
        results();
    end
endmodule : tb_top

// file: pkg/nvm_map.svh
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// ****************************************
// register offsets on the plain port
// ****************************************
`define NVM_ADDR_W 4
`define NVM_OFS_CTRL 4'h0
`define NVM_OFS_KEY 4'h1
`define NVM_OFS_DATA 4'h2
`define NVM_OFS_ADDR_LO 4'h3
`define NVM_OFS_ADDR_HI 4'h4
`define NVM_OFS_PTR_LO 4'h5
`define NVM_OFS_PTR_HI 4'h6
`define NVM_OFS_PTR_UP 4'h7
`define NVM_OFS_STATUS 4'h8

// ****************************************
// control and status register bit positions
// ****************************************
`define NVM_B_PGM 7
`define NVM_B_CFG 6
`define NVM_B_ERASE 4
`define NVM_B_ABORT 3
`define NVM_B_PERMIT 2
`define NVM_B_START 1
`define NVM_B_READ 0
`define NVM_B_DONE 0

// ****************************************
// key values and reset values
// ****************************************
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'hAA
`define NVM_BYTE_RST 8'h00
`define NVM_PTR_RST 22'h000000
`define NVM_EE_ERASED 8'hFF

// ****************************************
// timing
// ****************************************
`define NVM_CLK_NS 10
`define NVM_TICK_NS 1000
`define NVM_TICK_CYCLES ((`NVM_TICK_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)
`define NVM_ERASE_US 2000
`define NVM_EE_WRITE_US 4000

`endif

// file: pkg/nvm_pkg.sv
package nvm_pkg;

    // unlock progress on the key port
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_type;

    // long operation in flight
    typedef enum logic [1:0] {OP_IDLE, OP_EE_WRITE, OP_ERASE, OP_CFG} op_type;

    typedef struct packed {
        logic pgm_sel;
        logic cfg_sel;
        logic erase_sel;
        logic abort_flag;
        logic permit;
        logic start;
        logic read_pend;
        key_type key;
        op_type op;
        logic [7:0] data;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [21:0] ptr;
        logic done_flag;
        logic [7:0] tick_cnt;
        logic [23:0] timer;
        logic [7:0] rdata;
        logic ee_wr;
        logic stall;
        logic erase_act;
        logic cfg_act;
    } ctrl_state_type;

endpackage : nvm_pkg

// file: pkg/nvm_store_if.sv
`timescale 1ns/1ns
interface nvm_store_if #(parameter int ADDR_W = 10);
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input addr, input wdata, output rdata);
endinterface : nvm_store_if
